// ===== logic/mmcc_config.v
`timescale 1ns/1ps
`include "mmcc_map.vh"
module mmcc_config #(
   parameter OBIT_AW = `MMCC_OBIT_AW
)(
   input wire CLK_SYS, // 40 MHz system clock.
   input wire RST, // Synchronous reset, active high.
   input wire PSEL, // APB select.
   input wire PENABLE, // APB access phase.
   input wire PWRITE, // APB direction.
   input wire [31:0] PADDR, // APB byte address.
   input wire [31:0] PWDATA, // APB write data.
   output reg [31:0] PRDATA, // APB read data.
   output reg PREADY, // APB ready.
   output reg PSLVERR, // APB error, unmapped address.
   input wire MEM_REQ, // Master presents a memory address.
   input wire [29:0] MEM_ADDR, // Memory address.
   output reg MEM_HIT, // A bank claims the address.
   output reg [2:0] MEM_BANK, // Claiming bank.
   output reg MEM_WIDE64, // Claiming bank is in 64-bit mode.
   input wire BUS_BUSY, // Internal bus cycle in progress.
   output reg BUS_TIMEOUT, // Bus cycle ran too long, pulse.
   input wire REFRESH_ACK, // Refresh taken by the memory.
   output reg REFRESH_REQ, // Refresh request.
   output reg FLUSH_REQ, // Cache flush, pulse.
   input wire CHK_LOAD, // Capture check bits from memory.
   input wire [7:0] CHK_IN, // Check bits from memory.
   output reg FAST_DIAG, // Fast diagnostic mode.
   output reg FAST_DIAG_PASS2, // Second pass of fast diagnostic.
   output reg DIAG_CHECKBIT, // Diagnostic check-bit mode.
   output reg QBUS_ON_FIRST_IO, // Q-bus on the first I/O port.
   output reg SOFT_ERR_LOG, // Log correctable soft errors.
   output reg [7:0] DIAG_CHECK_BITS, // Diagnostic check bits.
   output reg [1:0] TMO_SCALE, // Bus timeout scale.
   output reg MEM_ERR_OFF, // Memory error handling disabled.
   output reg REF_SEL, // Refresh interval select.
   output reg [2:0] FORCE_BAD_PARITY, // Wrong parity forcing.
   output reg REF_STOP, // Refresh stopped.
   output reg REF_FORCE, // Refresh forced.
   output reg OBIT_IGNORE, // O-bits ignored.
   output reg OBIT_REPORT_OFF, // O-bit error reporting off.
   output reg [8:0] OBIT_SEGMENT, // O-bit segment address.
   output reg [2:0] OBIT_MASK, // O-bit mask.
   output reg [2:0] OBIT_MODE, // O-bit operation mode.
   output reg OBIT_RECON // Reconstruction mode selected.
);
   localparam ST_CLEAR = 1'b0;
   localparam ST_RUN = 1'b1;
   localparam OBIT_DEPTH = 1 << OBIT_AW;

   reg state;
   reg [OBIT_AW-1:0] clr_idx;
   reg [23:0] obit_mem [0:OBIT_DEPTH-1];
   reg [31:0] bank [0:7];
   reg [11:0] tmo_cnt;
   reg tmo_done;
   reg [31:0] rd_val;
   reg rd_err;
   reg [11:0] tmo_limit;
   wire ref_req;
   wire bk_hit;
   wire [2:0] bk_idx;
   wire [7:0] bk_valid;
   wire [39:0] bk_base;
   wire [15:0] bk_size;

   // Full-width copies of the group bases, so that only their upper bits are compared.
   localparam [31:0] BANK_BASE = `MMCC_BANK_BASE;
   localparam [31:0] OBIT_BASE = `MMCC_OBIT_BASE;

   // Address decode for the four register groups.
   wire is_bank = (PADDR[31:5] == BANK_BASE[31:5]) && (PADDR[1:0] == 2'h0);
   wire is_mode = (PADDR == `MMCC_MODE_ADDR);
   wire is_obam = (PADDR == `MMCC_OBAM_ADDR);
   wire is_obit = (PADDR[31:15] == OBIT_BASE[31:15]) && (PADDR[1:0] == 2'h0);
   wire [2:0] bidx = PADDR[4:2];
   wire [OBIT_AW-1:0] oidx = PADDR[OBIT_AW+1:2];

   // The O-bit array waits while it is still being cleared.
   wire obit_hold = is_obit && (state == ST_CLEAR);
   wire acc = PSEL && PENABLE;
   wire wr_now = acc && PREADY && PWRITE && !PSLVERR;
   wire wr_mode = wr_now && is_mode;

   // The mode register read image gathers its live fields.
   wire [31:0] mode_rd = {FAST_DIAG, FAST_DIAG_PASS2, DIAG_CHECKBIT,
                          QBUS_ON_FIRST_IO, SOFT_ERR_LOG, 1'b0, 1'b0,
                          DIAG_CHECK_BITS, 8'h00, TMO_SCALE, MEM_ERR_OFF,
                          REF_SEL, FORCE_BAD_PARITY, REF_STOP, REF_FORCE};
   wire [31:0] obam_rd = {15'h0000, OBIT_IGNORE, OBIT_REPORT_OFF,
                          OBIT_SEGMENT, OBIT_MASK, OBIT_MODE};

   // Bank registers, one per generate entry; unused bits stay zero.
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : gbank
         always @(posedge CLK_SYS) begin
            if (RST) begin
               bank[g] <= 32'h00000000; // [R1] [R2]
            end else if (wr_now && is_bank && (bidx == g)) begin
               bank[g] <= PWDATA & 32'h9f000007; // [R1] [R2] [R3] [R4]
            end
         end
         assign bk_valid[g] = bank[g][`MMCC_BK_VALID];
         assign bk_base[g*5+4:g*5] = bank[g][`MMCC_BK_BASE_HI:`MMCC_BK_BASE_LO];
         assign bk_size[g*2+1:g*2] = bank[g][`MMCC_BK_SIZE_HI:`MMCC_BK_SIZE_LO];
      end
   endgenerate

   mmcc_bank_match #(
      .NB(8)
   ) u_match (
      .valid(bk_valid),
      .base(bk_base),
      .size(bk_size),
      .addr(MEM_ADDR),
      .hit(bk_hit),
      .bank(bk_idx)
   );

   // The decode is registered so the memory side sees clean outputs.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         MEM_HIT <= 1'b0;
         MEM_BANK <= 3'h0;
         MEM_WIDE64 <= 1'b0;
      end else begin
         MEM_HIT <= MEM_REQ && bk_hit; // [R22]
         MEM_BANK <= bk_idx;
         MEM_WIDE64 <= MEM_REQ && bk_hit && bank[bk_idx][`MMCC_BK_WIDE]; // [R4]
      end
   end

   // Mode register; hardware capture of check bits beats a software write.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         FAST_DIAG <= 1'b0;
         FAST_DIAG_PASS2 <= 1'b0;
         DIAG_CHECKBIT <= 1'b0;
         QBUS_ON_FIRST_IO <= 1'b0;
         SOFT_ERR_LOG <= 1'b0;
         DIAG_CHECK_BITS <= 8'h00;
         TMO_SCALE <= 2'h0;
         MEM_ERR_OFF <= 1'b0;
         REF_SEL <= 1'b0;
         FORCE_BAD_PARITY <= 3'h0;
         REF_STOP <= 1'b0;
         REF_FORCE <= 1'b0;
      end else begin
         if (wr_mode) begin
            FAST_DIAG <= PWDATA[`MMCC_MD_FDM]; // [R5]
            FAST_DIAG_PASS2 <= PWDATA[`MMCC_MD_FDM2]; // [R6]
            DIAG_CHECKBIT <= PWDATA[`MMCC_MD_CHKM]; // [R7]
            QBUS_ON_FIRST_IO <= PWDATA[`MMCC_MD_QIO1]; // [R8]
            SOFT_ERR_LOG <= PWDATA[`MMCC_MD_SLOG]; // [R9]
            TMO_SCALE <= PWDATA[`MMCC_MD_TMO_HI:`MMCC_MD_TMO_LO]; // [R12]
            MEM_ERR_OFF <= PWDATA[`MMCC_MD_NOECC]; // [R13]
            REF_SEL <= PWDATA[`MMCC_MD_RSEL]; // [R14]
            FORCE_BAD_PARITY <= PWDATA[`MMCC_MD_PAR_HI:`MMCC_MD_PAR_LO]; // [R15]
            REF_STOP <= PWDATA[`MMCC_MD_NOREF]; // [R16]
            REF_FORCE <= PWDATA[`MMCC_MD_FREF]; // [R17]
         end
         if (CHK_LOAD) begin
            DIAG_CHECK_BITS <= CHK_IN; // [R11]
         end else if (wr_mode) begin
            DIAG_CHECK_BITS <= PWDATA[`MMCC_MD_CHK_HI:`MMCC_MD_CHK_LO]; // [R11]
         end
      end
   end

   // Flush is a write-one pulse and never reads back as set.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         FLUSH_REQ <= 1'b0;
      end else begin
         FLUSH_REQ <= wr_mode && PWDATA[`MMCC_MD_FLUSH]; // [R10]
      end
   end

   // O-bit address and mode register.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         OBIT_IGNORE <= 1'b0;
         OBIT_REPORT_OFF <= 1'b0;
         OBIT_SEGMENT <= 9'h000;
         OBIT_MASK <= 3'h0;
         OBIT_MODE <= 3'h0;
         OBIT_RECON <= 1'b1;
      end else begin
         if (wr_now && is_obam) begin
            OBIT_IGNORE <= PWDATA[`MMCC_OB_IGN]; // [R18]
            OBIT_REPORT_OFF <= PWDATA[`MMCC_OB_NOREP]; // [R19]
            OBIT_SEGMENT <= PWDATA[`MMCC_OB_SEG_HI:`MMCC_OB_SEG_LO]; // [R20]
            OBIT_MASK <= PWDATA[`MMCC_OB_MASK_HI:`MMCC_OB_MASK_LO]; // [R20]
            OBIT_MODE <= PWDATA[`MMCC_OB_MODE_HI:`MMCC_OB_MODE_LO]; // [R20]
         end
         // Follows the mode field one cycle late; X00 means reconstruction.
         OBIT_RECON <= (OBIT_MODE[1:0] == 2'h0); // [R20]
      end
   end

   // Reset cannot clear a large array at once, so a sweep clears one
   // entry per cycle; software reaching the array meanwhile is stalled.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         state <= ST_CLEAR;
         clr_idx <= {OBIT_AW{1'b0}};
      end else begin
         case (state)
            ST_CLEAR: begin
               clr_idx <= clr_idx + 1'b1;
               if (clr_idx == {OBIT_AW{1'b1}}) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
            default: begin
               state <= ST_CLEAR;
            end
         endcase
      end
   end

   // Single write port shared by the sweep and software.
   always @(posedge CLK_SYS) begin
      if (state == ST_CLEAR) begin
         obit_mem[clr_idx] <= 24'h000000; // [R21]
      end else if (wr_now && is_obit) begin
         obit_mem[oidx] <= PWDATA[`MMCC_OD_F1_HI:`MMCC_OD_F0_LO]; // [R21]
      end
   end

   // Read image of the small registers.
   always @* begin
      rd_val = 32'h00000000;
      rd_err = 1'b0;
      if (is_bank) begin
         rd_val = bank[bidx];
      end else if (is_mode) begin
         rd_val = mode_rd;
      end else if (is_obam) begin
         rd_val = obam_rd;
      end else if (!is_obit) begin
         rd_err = 1'b1;
      end
   end

   // APB slave: one wait state, ready and data come from flip-flops.
   // The write lands on the edge that samples ready high.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else if (acc && !PREADY && !obit_hold) begin
         PREADY <= 1'b1;
         PSLVERR <= rd_err;
         if (PWRITE || rd_err) begin
            PRDATA <= 32'h00000000;
         end else if (is_obit) begin
            PRDATA <= {8'h00, obit_mem[oidx]};
         end else begin
            PRDATA <= rd_val;
         end
      end else begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // Timeout length follows the scale field.
   always @* begin
      case (TMO_SCALE)
         2'h0: tmo_limit = `MMCC_TMO_CYC0; // [R12]
         2'h1: tmo_limit = `MMCC_TMO_CYC1;
         2'h2: tmo_limit = `MMCC_TMO_CYC2;
         default: tmo_limit = `MMCC_TMO_CYC3;
      endcase
   end

   // One pulse per overlong bus cycle; counting restarts when it ends.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         tmo_cnt <= 12'h000;
         tmo_done <= 1'b0;
         BUS_TIMEOUT <= 1'b0;
      end else if (!BUS_BUSY) begin
         tmo_cnt <= 12'h000;
         tmo_done <= 1'b0;
         BUS_TIMEOUT <= 1'b0;
      end else if (!tmo_done && (tmo_cnt == tmo_limit - 12'h001)) begin
         tmo_done <= 1'b1;
         BUS_TIMEOUT <= 1'b1; // [R12]
      end else begin
         tmo_cnt <= tmo_cnt + 12'h001;
         BUS_TIMEOUT <= 1'b0;
      end
   end

   mmcc_refresh u_ref (
      .clk(CLK_SYS),
      .rst(RST),
      .sel_alt(REF_SEL),
      .stop(REF_STOP),
      .force_ref(REF_FORCE),
      .ack(REFRESH_ACK),
      .req(ref_req)
   );

   // Refresh request passes through a flop to the pin.
   always @(posedge CLK_SYS) begin
      if (RST) begin
         REFRESH_REQ <= 1'b0;
      end else begin
         REFRESH_REQ <= ref_req && !REF_STOP; // [R16]
      end
   end
endmodule

// ===== include/mmcc_map.vh
// How it works
// R1: Bank valid flag bit 31, resets invalid.
// R2: Bank base 28:24; 4 MB compares 28:26.
// R3: Size 01=1 MB, 10=4 MB, 11=absent.
// R4: Bank bit 0 selects 64-bit mode.
// R5: Mode bit 31 enables fast diagnostic mode.
// R6: Mode bit 30 selects fast diagnostic pass two.
// R7: Mode bit 29 enables diagnostic check-bit mode.
// R8: Bit 28 moves Q-bus to first port.
// R9: Bit 27 enables soft error logging.
// R10: Writing one to bit 26 flushes cache.
// R11: Bits 24:17 hold diagnostic check bits.
// R12: Bits 8:7 scale bus timeout, 00=2600.
// R13: Bit 6 disables memory error handling.
// R14: Bit 5 selects refresh interval, 0=328.
// R15: Bits 4:2 force wrong bus parity.
// R16: Bit 1 stops memory refresh.
// R17: Bit 0 forces refresh.
// R18: O-bit bit 16 ignores O-bits.
// R19: O-bit bit 15 disables O-bit error reporting.
// R20: Segment 14:6, mask 5:3, mode 2:0.
// R21: O-bit data fields 23:12 and 11:0.
// R22: Respond only to valid, existing, matching banks.
`ifndef MMCC_MAP_VH
`define MMCC_MAP_VH
`define MMCC_BANK_BASE 32'h21018000
`define MMCC_MODE_ADDR 32'h21018048
`define MMCC_OBAM_ADDR 32'h2101804c
`define MMCC_OBIT_BASE 32'h21010000
`define MMCC_OBIT_AW 13
`define MMCC_BK_VALID 31
`define MMCC_BK_BASE_HI 28
`define MMCC_BK_BASE_LO 24
`define MMCC_BK_SIZE_HI 2
`define MMCC_BK_SIZE_LO 1
`define MMCC_BK_WIDE 0
`define MMCC_SZ_1MB 2'h1
`define MMCC_SZ_4MB 2'h2
`define MMCC_SZ_NONE 2'h3
`define MMCC_MD_FDM 31
`define MMCC_MD_FDM2 30
`define MMCC_MD_CHKM 29
`define MMCC_MD_QIO1 28
`define MMCC_MD_SLOG 27
`define MMCC_MD_FLUSH 26
`define MMCC_MD_CHK_HI 24
`define MMCC_MD_CHK_LO 17
`define MMCC_MD_TMO_HI 8
`define MMCC_MD_TMO_LO 7
`define MMCC_MD_NOECC 6
`define MMCC_MD_RSEL 5
`define MMCC_MD_PAR_HI 4
`define MMCC_MD_PAR_LO 2
`define MMCC_MD_NOREF 1
`define MMCC_MD_FREF 0
`define MMCC_OB_IGN 16
`define MMCC_OB_NOREP 15
`define MMCC_OB_SEG_HI 14
`define MMCC_OB_SEG_LO 6
`define MMCC_OB_MASK_HI 5
`define MMCC_OB_MASK_LO 3
`define MMCC_OB_MODE_HI 2
`define MMCC_OB_MODE_LO 0
`define MMCC_OD_F1_HI 23
`define MMCC_OD_F1_LO 12
`define MMCC_OD_F0_HI 11
`define MMCC_OD_F0_LO 0
`define MMCC_REF_CYC0 10'h148
`define MMCC_REF_CYC1 10'h290
`define MMCC_TMO_CYC0 12'ha28
`define MMCC_TMO_CYC1 12'h514
`define MMCC_TMO_CYC2 12'h28a
`define MMCC_TMO_CYC3 12'h145
`endif

// ===== logic/mmcc_bank_match.v
`timescale 1ns/1ps
`include "mmcc_map.vh"
module mmcc_bank_match #(
   parameter NB = 8
)(
   input wire [NB-1:0] valid, // Bank valid flags.
   input wire [NB*5-1:0] base, // Base address fields.
   input wire [NB*2-1:0] size, // Size codes.
   input wire [29:0] addr, // Memory address.
   output reg hit, // Some bank claims the address.
   output reg [2:0] bank // Lowest claiming bank.
);
   wire [NB-1:0] match;
   integer i;

   // Each bank compares its own base, at a width set by its size.
   genvar g;
   generate
      for (g = 0; g < NB; g = g + 1) begin : gb
         wire [4:0] b = base[g*5+4:g*5];
         wire [1:0] s = size[g*2+1:g*2];
         wire m1 = (s == `MMCC_SZ_1MB) && (addr[28:24] == b); // [R2] [R3]
         wire m4 = (s == `MMCC_SZ_4MB) && (addr[28:26] == b[4:2]); // [R2] [R3]
         assign match[g] = valid[g] && (m1 || m4); // [R22] [R1]
      end
   endgenerate

   // Overlapping banks resolve to the lowest index.
   always @* begin
      hit = 1'b0;
      bank = 3'h0;
      for (i = NB - 1; i >= 0; i = i - 1) begin
         if (match[i]) begin
            hit = 1'b1;
            bank = i[2:0];
         end
      end
   end
endmodule

// ===== logic/mmcc_refresh.v
`timescale 1ns/1ps
`include "mmcc_map.vh"
module mmcc_refresh (
   input wire clk, // System clock.
   input wire rst, // Synchronous reset.
   input wire sel_alt, // Alternate interval select.
   input wire stop, // Refresh stopped.
   input wire force_ref, // Continuous refresh.
   input wire ack, // Memory took the refresh.
   output reg req // Refresh request level.
);
   reg [9:0] cnt;
   wire [9:0] limit = sel_alt ? `MMCC_REF_CYC1 : `MMCC_REF_CYC0; // [R14]

   // The request holds until acknowledged; a stop drops it at once.
   // A new interval ending in the cycle of an acknowledge wins, so no refresh is lost.
   always @(posedge clk) begin
      if (rst) begin
         cnt <= 10'h000;
         req <= 1'b0;
      end else if (stop) begin
         cnt <= 10'h000; // [R16]
         req <= 1'b0;
      end else begin
         if (cnt == limit - 10'h001) begin
            req <= 1'b1; // [R14]
         end else if (req && ack) begin
            req <= force_ref; // [R17]
         end
         if (cnt == limit - 10'h001) begin
            cnt <= 10'h000;
         end else begin
            cnt <= cnt + 10'h001;
         end
      end
   end
endmodule

// ===== bench/mmcc_config_properties.sv
`timescale 1ns/1ps
`include "mmcc_map.vh"
module mmcc_config_properties (
   input wire CLK_SYS, // Clock.
   input wire RST, // Reset.
   input wire PSEL, // Select.
   input wire PENABLE, // Access phase.
   input wire PWRITE, // Direction.
   input wire [31:0] PADDR, // Address.
   input wire [31:0] PWDATA, // Write data.
   input wire PREADY, // Ready.
   input wire PSLVERR, // Error.
   input wire MEM_REQ, // Decode request.
   input wire MEM_HIT, // Decode hit.
   input wire BUS_BUSY, // Bus busy.
   input wire BUS_TIMEOUT, // Timeout pulse.
   input wire [1:0] TMO_SCALE, // Timeout scale.
   input wire REFRESH_REQ, // Refresh request.
   input wire REF_STOP, // Refresh stopped.
   input wire FLUSH_REQ, // Flush pulse.
   input wire [2:0] OBIT_MODE, // O-bit mode.
   input wire OBIT_RECON // Reconstruction.
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic [11:0] busy_n;
   wire [11:0] lim = `MMCC_TMO_CYC0 >> TMO_SCALE;
   // Busy cycles are counted here, saturating so a stuck bus cannot wrap the count.
   always @(posedge CLK_SYS) begin
      busy_n <= (RST || !BUS_BUSY) ? 12'h0 : busy_n + {11'h0, busy_n != 12'hfff};
   end
   sequence setup_s;
      PSEL && !PENABLE && PADDR[31:12] == 20'h21018;
   endsequence
   sequence access_s;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence flush_wr_s;
      PSEL && PENABLE && PREADY && PWRITE && PADDR == `MMCC_MODE_ADDR && PWDATA[26];
   endsequence
   reg_answer_a: assert property (setup_s ##1 access_s |=> PREADY)
      else $error("register answer late");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   error_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   hit_cause_a: assert property (MEM_HIT |-> $past(MEM_REQ))
      else $error("hit without request");
   flush_write_a: assert property (flush_wr_s |-> ##[1:2] FLUSH_REQ)
      else $error("flush missing");
   recon_lag_a: assert property (1'b1 |=> OBIT_RECON == ($past(OBIT_MODE[1:0]) == 2'h0))
      else $error("recon wrong");
   refresh_stop_a: assert property (REF_STOP [*2] |-> !REFRESH_REQ)
      else $error("refresh while stopped");
   timeout_limit_a: assert property (BUS_TIMEOUT |-> busy_n + 12'h2 >= lim && busy_n <= lim + 12'h2)
      else $error("timeout off limit");
   timeout_pulse_a: assert property (BUS_TIMEOUT |=> !BUS_TIMEOUT)
      else $error("timeout held");
endmodule
bind mmcc_config mmcc_config_properties i_props (.CLK_SYS, .RST, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PREADY, .PSLVERR, .MEM_REQ, .MEM_HIT, .BUS_BUSY, .BUS_TIMEOUT,
   .TMO_SCALE, .REFRESH_REQ, .REF_STOP, .FLUSH_REQ, .OBIT_MODE, .OBIT_RECON);

// ===== bench/mmcc_mem_model.sv
`timescale 1ns/1ps
// Memory side taking refresh requests; slow stands for a busy array.
module mmcc_mem_model (
   input wire clk, // Clock.
   input wire rst, // Reset.
   input wire req, // Refresh wanted.
   input wire slow, // Answer late.
   output logic ack // Refresh taken.
);
   logic [3:0] w;
   // The acknowledge is a one-cycle pulse that repeats while the request stays held.
   always @(posedge clk) begin
      if (rst || !req || ack) begin
         w <= 4'h0;
         ack <= 1'b0;
      end else begin
         w <= w + 4'h1;
         ack <= w == (slow ? 4'h8 : 4'h0);
      end
   end
endmodule

// ===== bench/mmcc_config_tb.sv
`timescale 1ns/1ps
`include "mmcc_map.vh"
module mmcc_config_tb;
   logic CLK_SYS = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, rerr, slow = 0;
   logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, rdat, w, bk [8], od [16];
   logic PREADY, PSLVERR, MEM_REQ = 0, BUS_BUSY = 0, CHK_LOAD = 0, ack, recon;
   logic tmo, rreq, fl;
   logic [29:0] MEM_ADDR = 0;
   logic [7:0] CHK_IN = 0;
   logic [4:0] dh;
   logic [21:0] mo;
   logic [16:0] ob;
   int bad_count = 0, cmp_count = 0, cyc = 0, fls = 0, efl = 0, n;
   mmcc_config #(.OBIT_AW(4)) i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
      .MEM_HIT(dh[4]), .MEM_BANK(dh[3:1]), .MEM_WIDE64(dh[0]), .BUS_BUSY(BUS_BUSY),
      .BUS_TIMEOUT(tmo), .REFRESH_ACK(ack), .REFRESH_REQ(rreq), .FLUSH_REQ(fl),
      .CHK_LOAD(CHK_LOAD), .CHK_IN(CHK_IN), .FAST_DIAG(mo[21]), .FAST_DIAG_PASS2(mo[20]),
      .DIAG_CHECKBIT(mo[19]), .QBUS_ON_FIRST_IO(mo[18]), .SOFT_ERR_LOG(mo[17]),
      .DIAG_CHECK_BITS(mo[16:9]), .TMO_SCALE(mo[8:7]), .MEM_ERR_OFF(mo[6]), .REF_SEL(mo[5]),
      .FORCE_BAD_PARITY(mo[4:2]), .REF_STOP(mo[1]), .REF_FORCE(mo[0]),
      .OBIT_IGNORE(ob[16]), .OBIT_REPORT_OFF(ob[15]), .OBIT_SEGMENT(ob[14:6]),
      .OBIT_MASK(ob[5:3]), .OBIT_MODE(ob[2:0]), .OBIT_RECON(recon));
   mmcc_mem_model i_mem (.clk(CLK_SYS), .rst(RST), .req(rreq), .slow(slow), .ack(ack));
   always #12.5 CLK_SYS = ~CLK_SYS;
   // Flush pulses are counted here; the cycle ceiling cuts a hung run short.
   always @(posedge CLK_SYS) begin
      cyc <= cyc + 1;
      fls <= fls + (fl === 1'b1);
      if (cyc == 40000) begin
         bad_count++;
         summarize;
      end
   end
   task chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task chkr(input int g, lo, hi);
      cmp_count++;
      if (g < lo || g > hi) begin
         bad_count++;
         $display("BAD %0t count %0d outside %0d to %0d", $time, g, lo, hi);
      end
   endtask
   // One APB transfer; the slave may stretch it, so ready is polled.
   task apb(input logic wr, input logic [31:0] a, d);
      @(posedge CLK_SYS);
      PSEL <= 1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1;
      do begin
         @(posedge CLK_SYS);
      end while (PREADY !== 1'b1);
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   // Waits for refresh high (0), a refresh acknowledge (1) or a timeout pulse (2).
   task wt(input int s);
      n = 0;
      while (n < 3000 && !(s == 0 ? rreq === 1'b1 : s == 1 ? ack === 1'b1 : tmo === 1'b1))
      begin
         @(posedge CLK_SYS);
         n++;
      end
   endtask
   // Lowest valid bank whose compared base bits match is named; hit and width need a request.
   function automatic logic [4:0] dec(input logic q, input logic [29:0] a);
      for (int i = 0; i < 8; i++) begin
         if (bk[i][31] && (bk[i][2:1] == 2'h1 && a[28:24] == bk[i][28:24]
             || bk[i][2:1] == 2'h2 && a[28:26] == bk[i][28:26])) begin
            return {q, 3'(i), q & bk[i][0]};
         end
      end
      return 5'h0;
   endfunction
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      w = $urandom(68943);
      repeat (20) @(posedge CLK_SYS);
      RST <= 0;
      chk(mo, 0);
      chk(ob, 0);
      chk(recon, 1);
      apb(0, `MMCC_OBIT_BASE, 0);
      chk(rdat, 0);
      for (int i = 0; i < 10; i++) begin
         apb(0, i < 8 ? `MMCC_BANK_BASE + 4 * i : i == 8 ? `MMCC_MODE_ADDR : `MMCC_OBAM_ADDR, 0);
         chk(rdat, 0);
      end
      apb(0, `MMCC_MODE_ADDR - 4, 0);
      chk({rerr, rdat[30:0]}, 32'h80000000);
      apb(1, `MMCC_BANK_BASE + 2, 32'hffffffff);
      apb(0, `MMCC_BANK_BASE, 0);
      chk(rdat, 0);
      for (int i = 0; i < 12; i++) begin
         w = $urandom;
         apb(1, `MMCC_MODE_ADDR, w);
         efl += w[26];
         apb(0, `MMCC_MODE_ADDR, 0);
         chk(rdat, w & 32'hf9fe01ff);
         chk(mo, {w[31:27], w[24:17], w[8:0]});
      end
      w = $urandom;
      @(posedge CLK_SYS);
      CHK_IN <= w[7:0];
      CHK_LOAD <= 1;
      @(posedge CLK_SYS);
      CHK_LOAD <= 0;
      apb(0, `MMCC_MODE_ADDR, 0);
      chk(rdat[24:17], w[7:0]);
      for (int i = 0; i < 8; i++) begin
         w = $urandom & (i[0] ? 32'hffffffff : 32'hfffffffc);
         apb(1, `MMCC_OBAM_ADDR, w);
         apb(0, `MMCC_OBAM_ADDR, 0);
         chk(rdat, w & 32'h1ffff);
         chk(ob, w[16:0]);
         chk(recon, w[1:0] == 2'h0);
      end
      for (int i = 0; i < 32; i++) begin
         if (i < 16) od[i] = $urandom;
         apb(i < 16, `MMCC_OBIT_BASE + 4 * (i % 16), od[i % 16]);
         if (i >= 16) chk(rdat, od[i - 16] & 32'hffffff);
      end
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 8; i++) begin
            bk[i] = $urandom;
            apb(1, `MMCC_BANK_BASE + 4 * i, bk[i]);
            apb(0, `MMCC_BANK_BASE + 4 * i, 0);
            bk[i] &= 32'h9f000007;
            chk(rdat, bk[i]);
         end
         for (int i = 0; i < 20; i++) begin
            w = $urandom;
            w[28:24] = bk[w[2:0]][28:24];
            @(posedge CLK_SYS);
            MEM_REQ <= w[31] | w[30];
            MEM_ADDR <= w[29:0];
            @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            chk(dh, dec(w[31] | w[30], w[29:0]));
         end
      end
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         apb(1, `MMCC_MODE_ADDR, 32'h2);
         apb(1, `MMCC_MODE_ADDR, s << 5);
         wt(0);
         chkr(n, 328 * (s + 1) - 4, 328 * (s + 1) + 2);
      end
      // Forced refresh keeps the request up across each acknowledge.
      apb(1, `MMCC_MODE_ADDR, 32'h1);
      for (int i = 0; i < 2; i++) begin
         wt(1);
         chkr(n, 1, 12);
         repeat (2) @(posedge CLK_SYS);
         chk(rreq, 1);
      end
      for (int s = 0; s < 4; s++) begin
         apb(1, `MMCC_MODE_ADDR, s << 7);
         BUS_BUSY <= 1;
         wt(2);
         chkr(n, (2600 >> s) - 2, (2600 >> s) + 2);
         BUS_BUSY <= 0;
      end
      chk(fls, efl);
      summarize;
   end
endmodule
